// >>> shared/mcc_pkg.sv
package mcc_pkg;

	localparam logic [4:0]  CFG_ADDR      = 5'h1e;

	localparam int          BIT_HD_ADV    = 15;
	localparam int          BIT_DET_DIS   = 14;
	localparam int          BIT_RESET     = 13;
	localparam int          BIT_LINK_WARN = 12;
	localparam int          BIT_NON_TRANS = 11;
	localparam int          BIT_FD_ADV    = 10;
	localparam int          BIT_SINGLE    = 9;
	localparam int          BIT_LOW_RATE  = 8;
	localparam int          BIT_FO_PECL   = 7;
	localparam int          BIT_LONG_WL   = 6;
	localparam int          BIT_SHORT_FO  = 5;
	localparam int          BIT_LOW_DRIVE = 4;
	localparam int          BIT_TP_PECL   = 3;
	localparam int          BIT_SHORT_TP  = 2;
	localparam int          BIT_SCR_EN    = 1;
	localparam int          BIT_SCR_RST   = 0;

	localparam logic        RST_HD_ADV    = 1'b0;
	localparam logic        RST_RESET     = 1'b0;
	localparam logic        RST_SCR_RST   = 1'b0;
	localparam logic [15:0] RST_CFG       = 16'h0000;

	localparam logic [10:0] SCR_SEED      = 11'h003;
	localparam int          SCR_TAP_A     = 10;
	localparam int          SCR_TAP_B     = 8;

	localparam int          CLK_PERIOD_NS = 40;
	localparam int          SW_RST_DLY_NS = 3000;
	localparam int          SW_RST_DLY_CYC = (SW_RST_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0]  SW_RST_DLY_LD = 7'(SW_RST_DLY_CYC);

	typedef enum logic [3:0] {
		ST_LOAD = 4'b0001,
		ST_RUN  = 4'b0010,
		ST_HOLD = 4'b0100,
		ST_WAIT = 4'b1000
	} mcc_state_t;

	typedef struct packed {
		mcc_state_t  st;
		logic [15:0] cfg;
		logic [15:0] rdata;
		logic [10:0] scr;
	} mcc_cfg_state_t;

	typedef struct packed {
		logic       busy;
		logic [6:0] cnt;
	} mcc_tmr_state_t;

endpackage

// >>> design/mcc_rst_timer.sv
`timescale 1ns/10ps
module mcc_rst_timer
	import mcc_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic start,
	output logic      busy,
	output logic      done
);

	mcc_tmr_state_t state_ff;
	mcc_tmr_state_t nxt_state;

	// A new start reloads the count, so a repeated reset request restarts the wait
	always_comb begin
		nxt_state = state_ff;
		if (start) begin
			nxt_state.busy = 1'b1;
			nxt_state.cnt  = SW_RST_DLY_LD;
		end else if (state_ff.busy) begin
			nxt_state.cnt = state_ff.cnt - 7'h01;
			if (state_ff.cnt == 7'h01) begin
				nxt_state.busy = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign busy = state_ff.busy;
	assign done = state_ff.busy && (state_ff.cnt == 7'h01) && !start;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_timer_load: assert property (start |=> state_ff.cnt == SW_RST_DLY_LD)
		else $error("Reset delay not loaded");
	a_done_single: assert property (done |=> !done && !busy)
		else $error("Delay done not a single pulse");

endmodule

// >>> design/mcc_config_reg.sv
`timescale 1ns/10ps
module mcc_config_reg
	import mcc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        link_warning_strap_pin,
	input  wire logic        duplex_strap_pin,
	input  wire logic        speed_strap_pin,
	input  wire logic        fiber_pecl_strap_pin,
	input  wire logic        copper_pecl_strap_pin,
	output logic             link_warning_active,
	output logic             non_transparent_mode,
	output logic             advertise_full_duplex,
	output logic             advertise_half_duplex,
	output logic             burst_detect_enable,
	output logic             rate_10_enable,
	output logic             rate_100_enable,
	output logic             fiber_pecl_mode,
	output logic             long_wavelength_mode,
	output logic             short_fiber_mode,
	output logic             low_copper_drive_mode,
	output logic             copper_pecl_mode,
	output logic             equalizer_bypass,
	output logic             scrambler_active,
	output logic             scrambler_seed_hold,
	output logic      [10:0] scrambler_state,
	output logic             soft_reset_busy
);

	mcc_cfg_state_t state_ff;
	mcc_cfg_state_t nxt_state;
	logic           wr_hit;
	logic           rd_hit;
	logic           tmr_start;
	logic           tmr_busy;
	logic           tmr_done;
	logic [15:0]    strap_cfg;

	function automatic logic is_cfg_addr(input logic [4:0] addr);
		return addr == CFG_ADDR;
	endfunction

	// Pin levels as they would land in each pin-defaulted field
	always_comb begin
		strap_cfg                = RST_CFG;
		strap_cfg[BIT_HD_ADV]    = RST_HD_ADV;
		strap_cfg[BIT_RESET]     = RST_RESET;
		strap_cfg[BIT_SCR_RST]   = RST_SCR_RST;
		strap_cfg[BIT_LINK_WARN] = link_warning_strap_pin;
		strap_cfg[BIT_NON_TRANS] = duplex_strap_pin;
		strap_cfg[BIT_FD_ADV]    = duplex_strap_pin;
		strap_cfg[BIT_DET_DIS]   = speed_strap_pin;
		strap_cfg[BIT_SINGLE]    = speed_strap_pin;
		strap_cfg[BIT_LOW_RATE]  = speed_strap_pin;
		strap_cfg[BIT_FO_PECL]   = fiber_pecl_strap_pin;
		strap_cfg[BIT_LONG_WL]   = fiber_pecl_strap_pin;
		strap_cfg[BIT_SHORT_FO]  = fiber_pecl_strap_pin;
		strap_cfg[BIT_TP_PECL]   = copper_pecl_strap_pin;
		strap_cfg[BIT_LOW_DRIVE] = copper_pecl_strap_pin;
		strap_cfg[BIT_SHORT_TP]  = copper_pecl_strap_pin;
		strap_cfg[BIT_SCR_EN]    = copper_pecl_strap_pin;
	end

	assign wr_hit    = reg_wr && is_cfg_addr(reg_addr);
	assign rd_hit    = reg_rd && is_cfg_addr(reg_addr);
	assign tmr_start = (state_ff.st == ST_HOLD);

	mcc_rst_timer u_rst_timer (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.start   (tmr_start),
		.busy    (tmr_busy),
		.done    (tmr_done)
	);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff.st)
			ST_LOAD: begin
				// Pins are caught by a clocked load after reset release, never by the reset itself
				nxt_state.cfg = strap_cfg;
				nxt_state.st  = ST_RUN;
			end
			ST_RUN, ST_WAIT: begin
				if (wr_hit) begin
					nxt_state.cfg = reg_wdata;
				end
				if (wr_hit && reg_wdata[BIT_RESET]) begin
					nxt_state.st = ST_HOLD;
				end else if ((state_ff.st == ST_WAIT) && tmr_done) begin
					nxt_state.st = ST_LOAD;
				end
			end
			ST_HOLD: begin
				// Bit reads 1 for one cycle, then the wait starts from its return to 0
				if (wr_hit) begin
					nxt_state.cfg = reg_wdata;
				end
				nxt_state.cfg[BIT_RESET] = 1'b0;
				nxt_state.st             = ST_WAIT;
			end
			default: begin
				nxt_state.st = ST_LOAD;
			end
		endcase

		nxt_state.rdata = 16'h0000;
		if (rd_hit) begin
			nxt_state.rdata = state_ff.cfg;
		end

		if (state_ff.cfg[BIT_SCR_RST]) begin
			nxt_state.scr = SCR_SEED;
		end else if (state_ff.cfg[BIT_SCR_EN]) begin
			nxt_state.scr = {state_ff.scr[9:0], state_ff.scr[SCR_TAP_A] ^ state_ff.scr[SCR_TAP_B]};
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff.st    <= ST_LOAD;
			state_ff.cfg   <= RST_CFG;
			state_ff.rdata <= 16'h0000;
			state_ff.scr   <= SCR_SEED;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign reg_rdata = state_ff.rdata;

	assign link_warning_active = state_ff.cfg[BIT_LINK_WARN];
	assign non_transparent_mode = state_ff.cfg[BIT_NON_TRANS];

	// Advertise bits have opposite senses; both are dead in transparent mode
	assign advertise_full_duplex = state_ff.cfg[BIT_NON_TRANS] && !state_ff.cfg[BIT_FD_ADV];
	assign advertise_half_duplex = state_ff.cfg[BIT_NON_TRANS] && state_ff.cfg[BIT_HD_ADV];

	assign burst_detect_enable = !state_ff.cfg[BIT_DET_DIS];

	assign rate_10_enable  = !state_ff.cfg[BIT_SINGLE] || state_ff.cfg[BIT_LOW_RATE];
	assign rate_100_enable = !state_ff.cfg[BIT_SINGLE] || !state_ff.cfg[BIT_LOW_RATE];

	assign fiber_pecl_mode = state_ff.cfg[BIT_FO_PECL];
	assign long_wavelength_mode = state_ff.cfg[BIT_LONG_WL] && !state_ff.cfg[BIT_FO_PECL]
		&& !state_ff.cfg[BIT_SHORT_FO];
	assign short_fiber_mode = state_ff.cfg[BIT_SHORT_FO] && !state_ff.cfg[BIT_FO_PECL];

	assign copper_pecl_mode = state_ff.cfg[BIT_TP_PECL];
	assign low_copper_drive_mode = state_ff.cfg[BIT_LOW_DRIVE] && !state_ff.cfg[BIT_TP_PECL];
	assign equalizer_bypass = state_ff.cfg[BIT_SHORT_TP] && !state_ff.cfg[BIT_TP_PECL];

	assign scrambler_active    = state_ff.cfg[BIT_SCR_EN];
	assign scrambler_seed_hold = state_ff.cfg[BIT_SCR_RST];
	assign scrambler_state     = state_ff.scr;

	// Busy covers the whole gap so the analog side can tell a reload is pending
	assign soft_reset_busy = (state_ff.st != ST_RUN);

	localparam int A_RST_DLY = 76;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_rdata_regread: assert property (rd_hit |=> reg_rdata == $past(state_ff.cfg))
		else $error("Read data does not match register");

	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("Read data not zero outside a read");

	a_liw_write: assert property (wr_hit && (state_ff.st == ST_RUN)
		|=> link_warning_active == $past(reg_wdata[BIT_LINK_WARN]))
		else $error("Link warning enable does not follow write");

	a_mode_write: assert property (wr_hit && (state_ff.st == ST_RUN)
		|=> non_transparent_mode == $past(reg_wdata[BIT_NON_TRANS]))
		else $error("Mode does not follow write");

	a_fd_ignored: assert property (!non_transparent_mode |-> !advertise_full_duplex)
		else $error("Full duplex advertised in transparent mode");

	a_hd_write: assert property (wr_hit && (state_ff.st == ST_RUN)
		|=> advertise_half_duplex == ($past(reg_wdata[BIT_NON_TRANS]) && $past(reg_wdata[BIT_HD_ADV])))
		else $error("Half duplex advertise wrong after write");

	a_detect_off: assert property (wr_hit && (state_ff.st == ST_RUN) && reg_wdata[BIT_DET_DIS]
		|=> !burst_detect_enable)
		else $error("Burst detection still enabled");

	a_rst_selfclr: assert property ((state_ff.st == ST_HOLD) |=> !state_ff.cfg[BIT_RESET])
		else $error("Reset bit did not clear itself");

	a_rst_delay: assert property ((state_ff.st == ST_HOLD) ##1 (!wr_hit || !reg_wdata[BIT_RESET])[*8]
		|-> ##(A_RST_DLY - 8) (state_ff.st == ST_LOAD))
		else $error("Software reset reload not at expected delay");

	// The release edge still runs the reset branch, so only a load seen with reset low is checked
	a_strap_load: assert property ((state_ff.st == ST_LOAD) && !sys_rst
		|=> state_ff.cfg == $past(strap_cfg))
		else $error("Pin defaults not loaded");

	a_single_rate: assert property (state_ff.cfg[BIT_SINGLE]
		|-> (rate_10_enable != rate_100_enable) && (rate_10_enable == state_ff.cfg[BIT_LOW_RATE]))
		else $error("Single rate selection wrong");

	a_fiber_ignore: assert property ((fiber_pecl_mode || state_ff.cfg[BIT_SHORT_FO])
		|-> !long_wavelength_mode)
		else $error("Wavelength not ignored");

	a_short_fo_ign: assert property (fiber_pecl_mode |-> !short_fiber_mode)
		else $error("Short fiber not ignored");

	a_copper_ignore: assert property (copper_pecl_mode |-> !low_copper_drive_mode && !equalizer_bypass)
		else $error("Copper options not ignored under PECL");

	a_seed_hold: assert property (scrambler_seed_hold |=> scrambler_state == SCR_SEED)
		else $error("Scrambler not held at seed");

	a_scr_stopped: assert property (!scrambler_seed_hold && !scrambler_active
		|=> $stable(scrambler_state))
		else $error("Scrambler ran while disabled");

	a_scr_running: assert property (!scrambler_seed_hold && scrambler_active
		|=> scrambler_state[10:1] == $past(scrambler_state[9:0]))
		else $error("Scrambler did not shift");

	c_soft_reset: cover property ((state_ff.st == ST_HOLD) ##[1:100] (state_ff.st == ST_LOAD));
	c_reg_read: cover property (wr_hit ##1 rd_hit);
	c_nontrans_fd: cover property (advertise_full_duplex && advertise_half_duplex);
	c_seed_release: cover property (scrambler_seed_hold ##1 !scrambler_seed_hold && scrambler_active);

endmodule

// >>> verification/mcc_mgmt_master.sv
`timescale 1ns/10ps
module mcc_mgmt_master (
	input  wire logic        clk_sys,
	output logic      [4:0]  reg_addr,
	output logic      [15:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [15:0] reg_rdata
);
	initial begin
		reg_addr  = 5'h00;
		reg_wdata = 16'h0000;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end
	// Idle data lines toggle so a stale word never looks valid
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule

// >>> verification/media_converter_config_reg_test.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module media_converter_config_reg_test;
	import mcc_pkg::*;
	logic        clk_sys;
	logic        sys_rst;
	logic [4:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [4:0]  strap;
	logic [14:0] mode_out;
	logic [10:0] scr_st;
	logic        busy;
	logic [15:0] rv;
	logic [10:0] s;
	int          failures;
	int          n_compared;
	int          cycles;
	int          n;
	logic [15:0] tbl [19] = '{16'h0000, 16'h0800, 16'h0c00, 16'h8800, 16'h8000, 16'h4000, 16'h0200,
		16'h0300, 16'h0080, 16'h00e0, 16'h0060, 16'h0040, 16'h0030, 16'h0018, 16'h0014, 16'h000c,
		16'h0002, 16'h1001, 16'hdffe};

	mcc_mgmt_master m (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	mcc_config_reg i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.link_warning_strap_pin(strap[4]), .duplex_strap_pin(strap[3]), .speed_strap_pin(strap[2]),
		.fiber_pecl_strap_pin(strap[1]), .copper_pecl_strap_pin(strap[0]),
		.link_warning_active(mode_out[14]), .non_transparent_mode(mode_out[13]),
		.advertise_full_duplex(mode_out[12]), .advertise_half_duplex(mode_out[11]),
		.burst_detect_enable(mode_out[10]), .rate_10_enable(mode_out[9]), .rate_100_enable(mode_out[8]),
		.fiber_pecl_mode(mode_out[7]), .long_wavelength_mode(mode_out[6]), .short_fiber_mode(mode_out[5]),
		.low_copper_drive_mode(mode_out[4]), .copper_pecl_mode(mode_out[3]),
		.equalizer_bypass(mode_out[2]), .scrambler_active(mode_out[1]),
		.scrambler_seed_hold(mode_out[0]), .scrambler_state(scr_st), .soft_reset_busy(busy));

	function automatic logic [14:0] exp_mode(input logic [15:0] v);
		return {v[12], v[11], v[11] & ~v[10], v[11] & v[15], ~v[14], ~v[9] | v[8], ~v[9] | ~v[8], v[7],
			v[6] & ~v[7] & ~v[5], v[5] & ~v[7], v[4] & ~v[3], v[3], v[2] & ~v[3], v[1], v[0]};
	endfunction

	function automatic logic [15:0] strap_word(input logic [4:0] p);
		return {1'b0, p[2], 1'b0, p[4], p[3], p[3], p[2], p[2], p[1], p[1], p[1], p[0], p[0], p[0], p[0], 1'b0};
	endfunction

	function automatic logic [10:0] lfsr(input logic [10:0] x);
		return {x[9:0], x[10] ^ x[8]};
	endfunction

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Whole run needs well under 1000 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			final_report();
		end
	end

	initial begin
		failures   = 0;
		n_compared = 0;
		cycles     = 0;
		sys_rst    = 1'b1;
		strap      = 5'h1f;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		m.rd(CFG_ADDR, rv);
		`CHK("power-up word", strap_word(strap), rv)
		foreach (tbl[i]) begin
			m.wr(CFG_ADDR, tbl[i]);
			m.rd(CFG_ADDR, rv);
			`CHK("readback", tbl[i], rv)
			`CHK("modes", exp_mode(tbl[i]), mode_out)
		end
		m.wr(5'h1d, 16'hffff);
		m.rd(5'h1d, rv);
		`CHK("unmapped read", 16'h0000, rv)
		m.rd(CFG_ADDR, rv);
		`CHK("after unmapped write", 16'hdffe, rv)
		@(posedge clk_sys);
		#1;
		`CHK("idle rdata", 16'h0000, reg_rdata)
		m.wr(CFG_ADDR, 16'h0001);
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK("seed hold", SCR_SEED, scr_st)
		m.wr(CFG_ADDR, 16'h0002);
		s = SCR_SEED;
		repeat (20) begin
			@(posedge clk_sys);
			#1;
			s = lfsr(s);
			`CHK("scrambler run", s, scr_st)
		end
		// Two more shifts happen while the disabling write is on the bus
		m.wr(CFG_ADDR, 16'h0000);
		s = lfsr(lfsr(s));
		repeat (5) @(posedge clk_sys);
		strap <= 5'h15;
		#1;
		`CHK("scrambler stopped", s, scr_st)
		m.wr(CFG_ADDR, 16'h3fff);
		#1;
		`CHK("busy", 1'b1, busy)
		m.rd(CFG_ADDR, rv);
		`CHK("self clear", 16'h1fff, rv)
		n = 2;
		while (busy === 1'b1 && n < 300) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		`CHK("reload delay", SW_RST_DLY_CYC + 2, n)
		m.rd(CFG_ADDR, rv);
		`CHK("reloaded word", strap_word(5'h15), rv)
		`CHK("reloaded modes", exp_mode(strap_word(5'h15)), mode_out)
		// Second power-up with other pin levels, so swapped pins show up
		@(posedge clk_sys);
		strap   <= 5'h0c;
		sys_rst <= 1'b1;
		@(posedge clk_sys);
		#1;
		`CHK("busy in reset", 1'b1, busy)
		`CHK("modes in reset", exp_mode(16'h0000), mode_out)
		`CHK("seed in reset", SCR_SEED, scr_st)
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		m.rd(CFG_ADDR, rv);
		`CHK("second power-up word", strap_word(5'h0c), rv)
		`CHK("second power-up modes", exp_mode(strap_word(5'h0c)), mode_out)
		final_report();
	end
endmodule
